// ---- hdl/btp_pkg.sv ----
// Package for the two-port bit-programmable GPIO block.
// Assumes a byte-wide register port with 8-bit addresses.
package btp_pkg;

	localparam logic [7:0] OFF_A_IN  = 8'h00_D0;
	localparam logic [7:0] OFF_A_OUT = 8'h00_D1;
	localparam logic [7:0] OFF_A_DIR = 8'h00_D2;
	localparam logic [7:0] OFF_A_FN  = 8'h00_D3;
	localparam logic [7:0] OFF_B_IN  = 8'h00_D4;
	localparam logic [7:0] OFF_B_OUT = 8'h00_D5;
	localparam logic [7:0] OFF_B_DIR = 8'h00_D6;
	localparam logic [7:0] OFF_B_FN  = 8'h00_D7;

	localparam int          PORT_B_WIDTH  = 6;
	localparam int          B_NO_DRV_BIT  = 5;
	localparam logic [7:0]  RST_DIR       = 8'h00_00;
	localparam logic [7:0]  RST_FN        = 8'h00_00;
	localparam logic [7:0]  RST_IN        = 8'h00_00;
	// Output value registers keep their contents over a full reset
	localparam logic [7:0]  POWERUP_OUT   = 8'h00_00;

	// One port's control set
	typedef struct packed {
		logic [7:0] inVal;
		logic [7:0] outVal;
		logic [7:0] dir;
		logic [7:0] fn;
	} btp_port_t;

	// Register bus request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} btp_req_t;

endpackage

// ---- hdl/btp_gpio.sv ----
// Two bit-programmable GPIO ports: port A of 8 lines, port B of 6 lines.
// Assumes a single-clock register master; pins arrive asynchronously.
// How it works
// - Fourteen lines: port A eight bits, each bit input or output.
// - Port B bits may carry special functions instead of plain I/O.
// - Push-pull on all pins except B5; port A bits may be open-drain.
// - Each register bit affects only the pin at the same position.
// - Four byte registers per port at D0-D3 and D4-D7.
// - Input bits read the current synchronized pin sample.
// - Output bits drive the output value register bit onto the pin.
// - The unused register bit of a pin keeps its value.
// - Pin passes two flip-flops, then the Schmitt stage, before the input register.
// - Input register writes are dropped on input bits, which load the sample on that same clock.
// - Port A direction bit 1 means output, 0 means input.
// - Output bits read back the requested value, not the pin level.
// - Output bits switch off their input Schmitt stage.
// - Registers update on rising edge; access any time in any order.
// - Port A output bits with function bit set drive open-drain.
// - Full reset clears direction and function registers; output values kept.
// - Stop recovery and watchdog events leave port registers unchanged.
`timescale 1ns/10ps

module btp_gpio #(
	parameter int A_WIDTH = 8,
	parameter int B_WIDTH = btp_pkg::PORT_B_WIDTH
) (
	// Clock and full reset
	input  wire logic                clk,
	input  wire logic                rst,
	// Register port
	input  wire logic [7:0]          regAddr,
	input  wire logic [7:0]          regWdata,
	input  wire logic                regWr,
	input  wire logic                regRd,
	output      logic [7:0]          regRdata,
	// Port A pins
	input  wire logic [A_WIDTH-1:0]  padAIn,
	output      logic [A_WIDTH-1:0]  padAOut,
	output      logic [A_WIDTH-1:0]  padAOe,
	// Port B pins
	input  wire logic [B_WIDTH-1:0]  padBIn,
	output      logic [B_WIDTH-1:0]  padBOut,
	output      logic [B_WIDTH-1:0]  padBOe,
	// Port B to special-function logic
	output      logic [B_WIDTH-1:0]  portBFnSel,
	output      logic [B_WIDTH-1:0]  portBSample,
	input  wire logic [B_WIDTH-1:0]  portBFnOut,
	input  wire logic [B_WIDTH-1:0]  portBFnOe
);

	btp_pkg::btp_req_t  req;
	btp_pkg::btp_port_t portA_q;
	btp_pkg::btp_port_t portB_q;
	logic [7:0]         aSync1_q;
	logic [7:0]         aSync2_q;
	logic [7:0]         bSync1_q;
	logic [7:0]         bSync2_q;
	logic [7:0]         aSchmitt;
	logic [7:0]         bSchmitt;
	logic [7:0]         aPad;
	logic [7:0]         bPad;
	logic [7:0]         rdata_d;
	logic [7:0]         bMask;
	logic [7:0]         b5Mask;
	logic [7:0]         aIn_q;
	logic [7:0]         aOut_q;
	logic [7:0]         aDir_q;
	logic [7:0]         aFn_q;
	logic [7:0]         bIn_q;
	logic [7:0]         bOut_q;
	logic [7:0]         bDir_q;
	logic [7:0]         bFn_q;

	assign req  = '{wr: regWr, rd: regRd, addr: regAddr, wdata: regWdata};
	assign aPad = 8'(padAIn);
	assign bPad = 8'(padBIn);
	assign bMask = 8'((9'h0_01 << B_WIDTH) - 9'h0_01);
	assign b5Mask = 8'(9'h0_01 << btp_pkg::B_NO_DRV_BIT);
	assign portA_q = '{inVal: aIn_q, outVal: aOut_q, dir: aDir_q, fn: aFn_q};
	assign portB_q = '{inVal: bIn_q, outVal: bOut_q, dir: bDir_q, fn: bFn_q};

	function automatic logic hit(input btp_pkg::btp_req_t r, input logic [7:0] off);
		return r.wr && (r.addr == off);
	endfunction

	// Gating the Schmitt stage on output bits saves its switching power
	assign aSchmitt = aSync2_q & ~portA_q.dir;
	assign bSchmitt = bSync2_q & ~portB_q.dir & bMask;

	// Raw pins meet two flip-flops before any gate; stage one feeds stage two only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aSync1_q <= btp_pkg::RST_IN;
			aSync2_q <= btp_pkg::RST_IN;
			bSync1_q <= btp_pkg::RST_IN;
			bSync2_q <= btp_pkg::RST_IN;
		end else begin
			aSync1_q <= aPad;
			aSync2_q <= aSync1_q;
			bSync1_q <= bPad;
			bSync2_q <= bSync1_q;
		end
	end

	// Input value registers: sample on input bits, hold software value on output bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aIn_q <= btp_pkg::RST_IN;
			bIn_q <= btp_pkg::RST_IN;
		end else begin
			aIn_q <= (portA_q.dir & (hit(req, btp_pkg::OFF_A_IN) ? req.wdata : portA_q.inVal))
				| aSchmitt;
			bIn_q <= ((portB_q.dir & (hit(req, btp_pkg::OFF_B_IN) ? req.wdata : portB_q.inVal))
				| bSchmitt) & bMask;
		end
	end

	// Output value registers have no reset term: full reset leaves them alone
	always_ff @(posedge clk) begin
		if (hit(req, btp_pkg::OFF_A_OUT))
			aOut_q <= req.wdata;
		if (hit(req, btp_pkg::OFF_B_OUT))
			bOut_q <= req.wdata & bMask;
	end

	// Direction and function registers; only rst is a full reset, so stop
	// recovery and watchdog events never reach here
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aDir_q <= btp_pkg::RST_DIR;
			aFn_q  <= btp_pkg::RST_FN;
			bDir_q <= btp_pkg::RST_DIR;
			bFn_q  <= btp_pkg::RST_FN;
		end else begin
			if (hit(req, btp_pkg::OFF_A_DIR))
				aDir_q <= req.wdata;
			if (hit(req, btp_pkg::OFF_A_FN))
				aFn_q <= req.wdata;
			if (hit(req, btp_pkg::OFF_B_DIR))
				bDir_q <= req.wdata & bMask;
			if (hit(req, btp_pkg::OFF_B_FN))
				bFn_q <= req.wdata & bMask;
		end
	end

	// Pin drivers
	always_comb begin
		for (int i = 0; i < A_WIDTH; i++) begin
			// Open-drain drives only the low level
			padAOut[i] = portA_q.outVal[i] & ~portA_q.fn[i];
			padAOe[i]  = portA_q.dir[i] & ~(portA_q.fn[i] & portA_q.outVal[i]);
		end
		for (int i = 0; i < B_WIDTH; i++) begin
			if (portB_q.fn[i] && portB_q.dir[i]) begin
				padBOut[i] = portBFnOut[i];
				padBOe[i]  = portBFnOe[i];
			end else begin
				padBOut[i] = portB_q.outVal[i];
				padBOe[i]  = portB_q.dir[i];
			end
			// B5 has no high-side driver; it can only pull low
			if (i == btp_pkg::B_NO_DRV_BIT && padBOut[i]) begin
				padBOe[i] = 1'b0;
			end
		end
	end

	assign portBFnSel  = portB_q.fn[B_WIDTH-1:0];
	assign portBSample = portB_q.inVal[B_WIDTH-1:0];

	// Read mux; output bits read the requested value, not the pad
	always_comb begin
		rdata_d = regRdata;
		if (req.rd) begin
			unique case (req.addr)
				btp_pkg::OFF_A_IN:  rdata_d = portA_q.inVal;
				btp_pkg::OFF_A_OUT: rdata_d = portA_q.outVal;
				btp_pkg::OFF_A_DIR: rdata_d = portA_q.dir;
				btp_pkg::OFF_A_FN:  rdata_d = portA_q.fn;
				btp_pkg::OFF_B_IN:  rdata_d = portB_q.inVal;
				btp_pkg::OFF_B_OUT: rdata_d = portB_q.outVal;
				btp_pkg::OFF_B_DIR: rdata_d = portB_q.dir;
				btp_pkg::OFF_B_FN:  rdata_d = portB_q.fn;
				default:            rdata_d = 8'h00_00;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			regRdata <= 8'h00_00;
		else
			regRdata <= rdata_d;
	end

	// Assertions
	a_dir_reset_clear: assert property (@(posedge clk) $rose(rst) |=> (portA_q.dir == 8'h00_00))
		else $error("direction not cleared by reset");
	a_fn_reset_clear: assert property (@(posedge clk) rst |=> (portB_q.fn == 8'h00_00))
		else $error("function not cleared by reset");
	a_out_drive_value: assert property (@(posedge clk) disable iff (rst)
		(portA_q.dir[0] && !portA_q.fn[0]) |-> (padAOe[0] && padAOut[0] == portA_q.outVal[0]))
		else $error("output bit not driven from output register");
	a_in_tracks_pin: assert property (@(posedge clk) disable iff (rst)
		(portA_q.dir[1] == 1'b0)[*4] |-> (portA_q.inVal[1] == $past(padAIn[1], 3)))
		else $error("input bit not the synchronized sample");
	a_in_hold_out: assert property (@(posedge clk) disable iff (rst)
		(portA_q.dir[2] && $past(portA_q.dir[2]) && !$past(hit(req, btp_pkg::OFF_A_IN)))
		|-> $stable(portA_q.inVal[2]))
		else $error("input bit of output pin changed");
	a_open_drain: assert property (@(posedge clk) disable iff (rst)
		(portA_q.dir[3] && portA_q.fn[3] && portA_q.outVal[3]) |-> !padAOe[3])
		else $error("open-drain bit drove high");
	a_b5_no_high: assert property (@(posedge clk) disable iff (rst)
		padBOe[btp_pkg::B_NO_DRV_BIT] |-> !padBOut[btp_pkg::B_NO_DRV_BIT])
		else $error("B5 drove high");
	a_in_dir_off: assert property (@(posedge clk) disable iff (rst)
		!portA_q.dir[4] |-> !padAOe[4])
		else $error("input bit drove the pad");
	a_read_latency: assert property (@(posedge clk) disable iff (rst)
		(regRd && regAddr == btp_pkg::OFF_A_DIR && !regWr) |=> (regRdata == $past(portA_q.dir)))
		else $error("read data wrong");

	// Reset values
	a_dir_a_reset: assert property (@(posedge clk) rst |=> (portA_q.dir == btp_pkg::RST_DIR))
		// Port A direction after a held reset
		else $error("port A direction not cleared");
	a_dir_b_reset: assert property (@(posedge clk) rst |=> (portB_q.dir == btp_pkg::RST_DIR))
		// Port B direction after a held reset
		else $error("port B direction not cleared");
	a_fn_a_reset: assert property (@(posedge clk) rst |=> (portA_q.fn == btp_pkg::RST_FN))
		// Port A function after a held reset
		else $error("port A function not cleared");
	a_in_reset_zero: assert property (@(posedge clk) rst
		|=> (portA_q.inVal == btp_pkg::RST_IN && portB_q.inVal == btp_pkg::RST_IN))
		else $error("input value not cleared by reset");
	a_oe_reset_low: assert property (@(posedge clk) rst
		|=> (padAOe == '0 && padBOe == '0))
		else $error("pin driven during reset");
	a_rdata_reset: assert property (@(posedge clk) rst
		|=> (regRdata == 8'h00_00))
		else $error("read data not cleared by reset");

	// Register writes and holds
	a_outval_a_write: assert property (@(posedge clk) disable iff (rst)
		hit(req, btp_pkg::OFF_A_OUT) |=> (portA_q.outVal == $past(regWdata)))
		else $error("port A output value write lost");
	a_outval_b_write: assert property (@(posedge clk) disable iff (rst)
		hit(req, btp_pkg::OFF_B_OUT) |=> (portB_q.outVal == ($past(regWdata) & bMask)))
		else $error("port B output value write lost");
	a_dir_a_write: assert property (@(posedge clk) disable iff (rst)
		hit(req, btp_pkg::OFF_A_DIR) |=> (portA_q.dir == $past(regWdata)))
		else $error("port A direction write lost");
	a_dir_b_write: assert property (@(posedge clk) disable iff (rst)
		hit(req, btp_pkg::OFF_B_DIR) |=> (portB_q.dir == ($past(regWdata) & bMask)))
		else $error("port B direction write lost");
	a_fn_a_write: assert property (@(posedge clk) disable iff (rst)
		hit(req, btp_pkg::OFF_A_FN) |=> (portA_q.fn == $past(regWdata)))
		else $error("port A function write lost");
	a_fn_b_write: assert property (@(posedge clk) disable iff (rst)
		hit(req, btp_pkg::OFF_B_FN) |=> (portB_q.fn == ($past(regWdata) & bMask)))
		else $error("port B function write lost");
	a_dir_a_hold: assert property (@(posedge clk) disable iff (rst)
		!hit(req, btp_pkg::OFF_A_DIR) |=> $stable(portA_q.dir))
		else $error("port A direction changed without write");
	a_dir_b_hold: assert property (@(posedge clk) disable iff (rst)
		!hit(req, btp_pkg::OFF_B_DIR) |=> $stable(portB_q.dir))
		else $error("port B direction changed without write");
	a_fn_a_hold: assert property (@(posedge clk) disable iff (rst)
		!hit(req, btp_pkg::OFF_A_FN) |=> $stable(portA_q.fn))
		else $error("port A function changed without write");
	a_fn_b_hold: assert property (@(posedge clk) disable iff (rst)
		!hit(req, btp_pkg::OFF_B_FN) |=> $stable(portB_q.fn))
		else $error("port B function changed without write");

	// Input value registers and synchronizers
	a_in_wr_out_a: assert property (@(posedge clk) disable iff (rst)
		hit(req, btp_pkg::OFF_A_IN) |=> (((portA_q.inVal ^ $past(regWdata)) & $past(portA_q.dir)) == 8'h00_00))
		else $error("port A input write not kept on output bit");
	a_in_wr_out_b: assert property (@(posedge clk) disable iff (rst)
		hit(req, btp_pkg::OFF_B_IN) |=> (((portB_q.inVal ^ $past(regWdata)) & $past(portB_q.dir)) == 8'h00_00))
		else $error("port B input write not kept on output bit");
	a_in_wr_in_a: assert property (@(posedge clk) disable iff (rst)
		hit(req, btp_pkg::OFF_A_IN) |=> (((portA_q.inVal ^ $past(aSync2_q)) & ~$past(portA_q.dir)) == 8'h00_00))
		else $error("port A input write not replaced by sample");
	a_in_wr_in_b: assert property (@(posedge clk) disable iff (rst)
		hit(req, btp_pkg::OFF_B_IN) |=> (((portB_q.inVal ^ $past(bSync2_q)) & ~$past(portB_q.dir)) == 8'h00_00))
		else $error("port B input write not replaced by sample");
	a_in_hold_a: assert property (@(posedge clk) disable iff (rst)
		!hit(req, btp_pkg::OFF_A_IN) |=> (((portA_q.inVal ^ $past(portA_q.inVal)) & $past(portA_q.dir)) == 8'h00_00))
		else $error("port A input bit of output pin changed");
	a_in_hold_b: assert property (@(posedge clk) disable iff (rst)
		!hit(req, btp_pkg::OFF_B_IN) |=> (((portB_q.inVal ^ $past(portB_q.inVal)) & $past(portB_q.dir)) == 8'h00_00))
		else $error("port B input bit of output pin changed");
	a_b_in_sample: assert property (@(posedge clk) disable iff (rst)
		(portB_q.dir[0] == 1'b0)[*4] |-> (portB_q.inVal[0] == $past(padBIn[0], 3)))
		else $error("port B input bit not the synchronized sample");
	a_sync_two_a: assert property (@(posedge clk) disable iff (rst)
		(!$past(rst) && !$past(rst, 2)) |-> (aSync2_q == $past(aPad, 2)))
		else $error("port A synchronizer not two stages");
	a_sync_two_b: assert property (@(posedge clk) disable iff (rst)
		(!$past(rst) && !$past(rst, 2)) |-> (bSync2_q == $past(bPad, 2)))
		else $error("port B synchronizer not two stages");
	a_b_upper_zero: assert property (@(posedge clk) disable iff (rst)
		(((portB_q.dir | portB_q.fn | portB_q.inVal) & ~bMask) == 8'h00_00))
		else $error("port B bit beyond its width set");

	// Pin drivers
	a_od_drive_low: assert property (@(posedge clk) disable iff (rst)
		(((portA_q.dir & portA_q.fn & ~portA_q.outVal) & ~(8'(padAOe) & ~8'(padAOut))) == 8'h00_00))
		else $error("open-drain bit failed to pull low");
	a_pp_a_drive: assert property (@(posedge clk) disable iff (rst)
		(((portA_q.dir & ~portA_q.fn) & ~8'(padAOe)) == 8'h00_00))
		else $error("push-pull bit not driven");
	a_pp_a_value: assert property (@(posedge clk) disable iff (rst)
		(((portA_q.dir & ~portA_q.fn) & (8'(padAOut) ^ portA_q.outVal)) == 8'h00_00))
		else $error("push-pull bit value wrong");
	a_in_a_off: assert property (@(posedge clk) disable iff (rst)
		((~portA_q.dir & 8'(padAOe)) == 8'h00_00))
		else $error("port A input pin driven");
	a_in_b_off: assert property (@(posedge clk) disable iff (rst)
		((~portB_q.dir & 8'(padBOe)) == 8'h00_00))
		else $error("port B input pin driven");
	a_b_plain_value: assert property (@(posedge clk) disable iff (rst)
		(((portB_q.dir & ~portB_q.fn) & (8'(padBOut) ^ portB_q.outVal)) == 8'h00_00))
		else $error("port B output bit value wrong");
	a_b_fn_route: assert property (@(posedge clk) disable iff (rst)
		(((portB_q.dir & portB_q.fn) & (8'(padBOut) ^ 8'(portBFnOut))) == 8'h00_00))
		else $error("port B special function value not routed");
	a_b_fn_oe: assert property (@(posedge clk) disable iff (rst)
		(((portB_q.dir & portB_q.fn & ~b5Mask) & (8'(padBOe) ^ 8'(portBFnOe))) == 8'h00_00))
		else $error("port B special function enable not routed");
	a_b_in_plain: assert property (@(posedge clk) disable iff (rst)
		((~portB_q.dir & portB_q.fn & 8'(padBOe)) == 8'h00_00))
		else $error("port B function input bit driven");
	a_b5_low_drive: assert property (@(posedge clk) disable iff (rst)
		(portB_q.dir[5] && !portB_q.fn[5] && !portB_q.outVal[5]) |-> (padBOe[5] && !padBOut[5]))
		else $error("bit 5 failed to pull low");

	// Read port
	a_rd_a_in: assert property (@(posedge clk) disable iff (rst)
		(regRd && !regWr && regAddr == btp_pkg::OFF_A_IN) |=> (regRdata == $past(portA_q.inVal)))
		else $error("port A input value read wrong");
	a_rd_a_out: assert property (@(posedge clk) disable iff (rst)
		(regRd && !regWr && regAddr == btp_pkg::OFF_A_OUT) |=> (regRdata == $past(portA_q.outVal)))
		else $error("port A output value read wrong");
	a_rd_a_fn: assert property (@(posedge clk) disable iff (rst)
		(regRd && !regWr && regAddr == btp_pkg::OFF_A_FN) |=> (regRdata == $past(portA_q.fn)))
		else $error("port A function read wrong");
	a_rd_b_in: assert property (@(posedge clk) disable iff (rst)
		(regRd && !regWr && regAddr == btp_pkg::OFF_B_IN) |=> (regRdata == $past(portB_q.inVal)))
		else $error("port B input value read wrong");
	a_rd_b_out: assert property (@(posedge clk) disable iff (rst)
		(regRd && !regWr && regAddr == btp_pkg::OFF_B_OUT) |=> (regRdata == $past(portB_q.outVal)))
		else $error("port B output value read wrong");
	a_rd_b_dir: assert property (@(posedge clk) disable iff (rst)
		(regRd && !regWr && regAddr == btp_pkg::OFF_B_DIR) |=> (regRdata == $past(portB_q.dir)))
		else $error("port B direction read wrong");
	a_rd_b_fn: assert property (@(posedge clk) disable iff (rst)
		(regRd && !regWr && regAddr == btp_pkg::OFF_B_FN) |=> (regRdata == $past(portB_q.fn)))
		else $error("port B function read wrong");
	a_rd_unmapped: assert property (@(posedge clk) disable iff (rst)
		(regRd && (regAddr < btp_pkg::OFF_A_IN || regAddr > btp_pkg::OFF_B_FN)) |=> (regRdata == 8'h00_00))
		else $error("unmapped read not zero");
	a_rd_hold: assert property (@(posedge clk) disable iff (rst)
		!regRd |=> $stable(regRdata))
		else $error("read data changed without read");

endmodule // btp_gpio

// ---- tb/btp_pad_model.sv ----
// Pin-side model: whatever is wired to one GPIO port outside the chip.
// Assumes the enable is high while the block drives the pin.
`timescale 1ns/10ps

module btp_pad_model #(
	parameter int W = 8
) (
	// Block side
	input  wire logic [W-1:0] pinOut,
	input  wire logic [W-1:0] pinOe,
	// Board side
	input  wire logic [W-1:0] extVal,
	input  wire logic         contend,
	output      logic [W-1:0] pinIn
);
	// A fault on the board can override a driven pin; undriven pins follow the board
	assign pinIn = (pinOe & (contend ? ~pinOut : pinOut)) | (~pinOe & extVal);
endmodule // btp_pad_model

// ---- tb/bitwise_two_port_gpio_bench.sv ----
// Self-checking bench for the two-port GPIO block.
// Assumes one 125 MHz clock and a bus master that never waits.
`timescale 1ns/10ps

module bitwise_two_port_gpio_bench;
	logic       clk = 0, rst = 1, regWr = 0, regRd = 0, contend = 0;
	logic [7:0] regAddr = '0, regWdata = '0, regRdata, aOut, aOe, aIn, extA = '0;
	logic [5:0] bOut, bOe, bIn, extB = '0, fnSel, sample, fnOut = '0, fnOe = '0;
	logic [7:0] v [4], base, m, sel, eV, eOe, la, lb;
	int         n_errors = 0, compares = 0, seed = 15373;
	always #4 clk = ~clk;
	btp_gpio i_btp_gpio (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .padAIn(aIn), .padAOut(aOut), .padAOe(aOe), .padBIn(bIn),
		.padBOut(bOut), .padBOe(bOe), .portBFnSel(fnSel), .portBSample(sample), .portBFnOut(fnOut),
		.portBFnOe(fnOe));
	btp_pad_model #(.W(8)) i_pad_a (.pinOut(aOut), .pinOe(aOe), .extVal(extA), .contend(contend), .pinIn(aIn));
	btp_pad_model #(.W(6)) i_pad_b (.pinOut(bOut), .pinOe(bOe), .extVal(extB), .contend(contend), .pinIn(bIn));
	function automatic logic [7:0] expIn(input logic [7:0] ext, dir, w, msk);
		return ((ext & ~dir) | (w & dir)) & msk;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regWr <= 1'b1;
		regRd <= 1'b0;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		regRd <= 1'b1;
		regWr <= 1'b0;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		@(posedge clk);
		chk(regRdata, exp, what);
	endtask
	task automatic ctrlReset();
		for (int i = 2; i < 8; i++) if (i != 4 && i != 5) rd(8'(btp_pkg::OFF_A_IN + i), 8'h00, "reset ctrl");
	endtask
	task automatic close_out();
		$display("Counts: %0d compares, %0d errors", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		close_out();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		ctrlReset();
		rd(8'h00_D8, 8'h00, "unmapped");
		$display("Test reset done");
		repeat (40) begin
			for (int p = 0; p < 2; p++) begin
				base = p ? btp_pkg::OFF_B_IN : btp_pkg::OFF_A_IN;
				m = p ? 8'h00_3F : 8'h00_FF;
				for (int k = 0; k < 4; k++) v[k] = $random(seed) & m;
				extA <= $random(seed);
				extB <= $random(seed);
				contend <= $random(seed);
				fnOut <= $random(seed);
				fnOe <= $random(seed);
				wr(base + 8'h00_03, 8'h00);
				wr(base + 8'h00_01, v[1]);
				wr(base + 8'h00_02, v[2]);
				wr(base, v[0]);
				wr(base + 8'h00_03, v[3]);
				regWr <= 1'b0;
				repeat (4) @(posedge clk);
				#1;
				if (p == 0) begin
					la = v[1];
					eOe = v[2] & ~(v[3] & v[1]);
					chk(aOe, eOe, "A enable");
					chk(aOut & eOe, v[1] & eOe, "A value");
				end else begin
					lb = v[1];
					sel = v[3] & v[2];
					eV = (sel & {2'b00, fnOut}) | (~sel & v[1]);
					eOe = (sel & {2'b00, fnOe}) | (~sel & v[2]);
					eOe[5] = eOe[5] & ~eV[5];
					chk({2'b00, bOe}, eOe, "B enable");
					chk({2'b00, bOut} & eOe, eV & eOe, "B value");
					chk({2'b00, fnSel}, v[3], "B function");
					chk({2'b00, sample}, expIn({2'b00, extB}, v[2], v[0], m), "B sample");
				end
				rd(base, expIn(p ? {2'b00, extB} : extA, v[2], v[0], m), "input value");
				rd(base + 8'h00_01, v[1], "output value");
				rd(base + 8'h00_02, v[2], "direction");
				rd(base + 8'h00_03, v[3], "function");
			end
		end
		$display("Test random done");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		ctrlReset();
		rd(btp_pkg::OFF_A_OUT, la, "A out kept");
		rd(btp_pkg::OFF_B_OUT, lb, "B out kept");
		rd(btp_pkg::OFF_A_IN, extA, "A in after reset");
		$display("Test rereset done");
		close_out();
	end
endmodule // bitwise_two_port_gpio_bench
